/* core/sdsc_ahb_slave.sv */
// ahb-lite slave front end: writes with no wait, reads with one wait state
`timescale 1ns/1ps
module sdsc_ahb_slave (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	sdsc_reg_if.bus regs
);
	logic ph_valid;
	logic ph_write;
	logic [7:0] ph_addr;
	logic rd_done;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= 8'h00;
		end else if (hready) begin
			ph_valid <= hsel && htrans[1];
			ph_write <= hwrite;
			ph_addr <= haddr[7:0];
		end
	end

	// read data is registered so hrdata never follows the register file directly
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_done <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else if (ph_valid && !ph_write && !rd_done) begin
			rd_done <= 1'b1;
			hrdata <= regs.rdata;
		end else begin
			rd_done <= 1'b0;
		end
	end

	assign hreadyout = !(ph_valid && !ph_write && !rd_done);
	assign hresp = 1'b0;
	assign regs.wr = ph_valid && ph_write;
	assign regs.rd = ph_valid && !ph_write && !rd_done;
	assign regs.addr = ph_addr;
	assign regs.wdata = hwdata;
endmodule

/* core/sdsc_params.svh */
// constants for the segment display scan driver
`ifndef SDSC_PARAMS_SVH
`define SDSC_PARAMS_SVH
`define SDSC_ADDR_CTRL 8'h00
`define SDSC_ADDR_SRC_LO 8'h04
`define SDSC_ADDR_SRC_HI 8'h08
`define SDSC_ADDR_GP_OUT 8'h0c
`define SDSC_ADDR_STATUS 8'h10
`define SDSC_ADDR_INT_STAT 8'h14
`define SDSC_ADDR_INT_MASK 8'h18
`define SDSC_ADDR_OUT_WORD 8'h1c
`define SDSC_CTRL_EIGHT 2
`define SDSC_CTRL_INV_DATA 1
`define SDSC_CTRL_INV_LATCH 0
`define SDSC_CTRL_EXEC 8
`define SDSC_CTRL_RESTART 9
`define SDSC_CTRL_AREA0_LSB 12
`define SDSC_CTRL_AREA1_LSB 14
`define SDSC_MODE_MAX 8'h07
`define SDSC_STEP_LAST 4'hb
`define SDSC_FLAG_BIT_EIGHT 12
`define SDSC_FLAG_BIT_FOUR 8
`define SDSC_INT_ROUND 0
`define SDSC_INT_ERROR 1
`define SDSC_RST_WORD 32'h0000_0000
`define SDSC_SCAN_US 1000
`define SDSC_CLK_MHZ 20
`endif

/* core/sdsc_pkg.sv */
// types and helpers shared by the segment display scan driver
package sdsc_pkg;
	typedef enum logic [1:0] {
		SDSC_IDLE = 2'b00,
		SDSC_RUN = 2'b01,
		SDSC_FAULT = 2'b10
	} sdsc_state_type;

	function automatic logic [1:0] sdsc_digit(input logic [3:0] step);
		sdsc_digit = 2'(step / 4'h3);
	endfunction

	function automatic logic [1:0] sdsc_phase(input logic [3:0] step);
		sdsc_phase = 2'(step % 4'h3);
	endfunction
endpackage

/* core/sdsc_reg_if.sv */
// register access strobes between the bus front end and the scan core
`timescale 1ns/1ps
interface sdsc_reg_if;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport bus(output wr, output rd, output addr, output wdata, input rdata);
	modport regs(input wr, input rd, input addr, input wdata, output rdata);
endinterface

/* core/sdsc_tick_div.sv */
// divider that makes the one-cycle scan enable
`timescale 1ns/1ps
module sdsc_tick_div #(
	parameter int DIV = 20000
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	input wire logic run,
	output logic tick
);
	localparam int W = $clog2(DIV);
	logic [W-1:0] count;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= '0;
		end else if (clear || !run || count == W'(DIV - 1)) begin
			count <= '0;
		end else begin
			count <= count + W'(1);
		end
	end

	assign tick = run && !clear && count == W'(DIV - 1);
endmodule

/* core/sdsc_top.sv */
// segment display scan driver with ahb-lite registers
// Function
// - control value picks digits and polarities
// - no display activity unless executing
// - eight digits: high word gives upper four
// - twelve scan cycles per round, repeating
// - four digits: data 0-3, strobes 4-7
// - eight digits: data 0-7, strobes 8-11
// - round flag on bit 12 or 8
// - sequence starts fresh at every start
// - error on split areas with eight digits, or bad operand
// - busy bit on while executing
// - sources reread every round
// - unused output bits stay ordinary outputs
// - plain setting follows positive-logic outputs
`timescale 1ns/1ps
`include "sdsc_params.svh"
module sdsc_top #(
	parameter int SCAN_US = `SDSC_SCAN_US,
	parameter int SCAN_DIV = SCAN_US * `SDSC_CLK_MHZ
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [15:0] seg_word,
	output logic display_busy_bit,
	output logic error_flag,
	output logic irq
);
	import sdsc_pkg::*;

	sdsc_reg_if regs();

	logic [7:0] ctrl_mode;
	logic exec_en;
	logic [1:0] area0;
	logic [1:0] area1;
	logic [15:0] src_lo;
	logic [15:0] src_hi;
	logic [15:0] gp_out;
	logic [15:0] snap_lo;
	logic [15:0] snap_hi;
	logic [1:0] int_stat;
	logic [1:0] int_mask;
	logic [3:0] step;
	sdsc_state_type state;
	sdsc_state_type next_state;
	logic [15:0] next_word;
	logic wr_ctrl;
	logic restart;
	logic start;
	logic tick;
	logic running;
	logic eight;
	logic inv_data;
	logic inv_latch;
	logic err_cond;
	logic round_evt;
	logic err_evt;
	logic [1:0] digit;
	logic latch_on;
	logic [3:0] nib_lo;
	logic [3:0] nib_hi;
	logic [3:0] strobes;
	logic flag;

	sdsc_ahb_slave u_bus (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.regs(regs.bus)
	);

	sdsc_tick_div #(
		.DIV(SCAN_DIV)
	) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(start),
		.run(running),
		.tick(tick)
	);

	assign wr_ctrl = regs.wr && regs.addr == `SDSC_ADDR_CTRL;
	assign restart = wr_ctrl && regs.wdata[`SDSC_CTRL_RESTART] && running;

	// control value decode
	assign eight = ctrl_mode[`SDSC_CTRL_EIGHT];
	assign inv_data = ctrl_mode[`SDSC_CTRL_INV_DATA];
	assign inv_latch = ctrl_mode[`SDSC_CTRL_INV_LATCH];
	// a value above seven is refused rather than truncated
	assign err_cond = ctrl_mode > `SDSC_MODE_MAX || (eight && area0 != area1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_mode <= 8'h00;
			exec_en <= 1'b0;
			area0 <= 2'h0;
			area1 <= 2'h0;
		end else if (wr_ctrl) begin
			ctrl_mode <= regs.wdata[7:0];
			exec_en <= regs.wdata[`SDSC_CTRL_EXEC];
			area0 <= regs.wdata[`SDSC_CTRL_AREA0_LSB +: 2];
			area1 <= regs.wdata[`SDSC_CTRL_AREA1_LSB +: 2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_lo <= 16'h0000;
			src_hi <= 16'h0000;
			gp_out <= 16'h0000;
			int_mask <= 2'h0;
		end else if (regs.wr) begin
			if (regs.addr == `SDSC_ADDR_SRC_LO) begin
				src_lo <= regs.wdata[15:0];
			end
			if (regs.addr == `SDSC_ADDR_SRC_HI) begin
				src_hi <= regs.wdata[15:0];
			end
			if (regs.addr == `SDSC_ADDR_GP_OUT) begin
				gp_out <= regs.wdata[15:0];
			end
			if (regs.addr == `SDSC_ADDR_INT_MASK) begin
				int_mask <= regs.wdata[1:0];
			end
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			SDSC_IDLE: begin
				if (exec_en) begin
					next_state = err_cond ? SDSC_FAULT : SDSC_RUN;
				end
			end
			SDSC_RUN: begin
				if (!exec_en) begin
					next_state = SDSC_IDLE;
				end else if (err_cond) begin
					next_state = SDSC_FAULT;
				end
			end
			SDSC_FAULT: begin
				if (!exec_en) begin
					next_state = SDSC_IDLE;
				end else if (!err_cond) begin
					next_state = SDSC_RUN;
				end
			end
			default: begin
				next_state = SDSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= SDSC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign running = state == SDSC_RUN;
	assign display_busy_bit = running;
	assign error_flag = state == SDSC_FAULT;
	// each entry into execution, and an explicit restart, begins a round afresh
	assign start = (running != (next_state == SDSC_RUN) && !running) || restart;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step <= 4'h0;
		end else if (start) begin
			step <= 4'h0;
		end else if (running && tick) begin
			step <= (step == `SDSC_STEP_LAST) ? 4'h0 : step + 4'h1;
		end
	end

	// sources are frozen for one round so a digit never changes mid-latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			snap_lo <= 16'h0000;
			snap_hi <= 16'h0000;
		end else if (start || (running && tick && step == `SDSC_STEP_LAST)) begin
			snap_lo <= src_lo;
			snap_hi <= src_hi;
		end
	end

	// three scan cycles per digit: data set up, strobe on, strobe off
	assign digit = sdsc_digit(step);
	assign latch_on = sdsc_phase(step) == 2'h1;
	assign nib_lo = snap_lo[{digit, 2'b00} +: 4] ^ {4{inv_data}};
	assign nib_hi = snap_hi[{digit, 2'b00} +: 4] ^ {4{inv_data}};
	assign strobes = (latch_on ? 4'h1 << digit : 4'h0) ^ {4{inv_latch}};
	assign flag = step == `SDSC_STEP_LAST;

	always_comb begin
		next_word = gp_out;
		if (running) begin
			next_word[3:0] = nib_lo;
			if (eight) begin
				next_word[7:4] = nib_hi;
				next_word[11:8] = strobes;
				next_word[`SDSC_FLAG_BIT_EIGHT] = flag;
			end else begin
				next_word[7:4] = strobes;
				next_word[`SDSC_FLAG_BIT_FOUR] = flag;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seg_word <= 16'h0000;
		end else begin
			seg_word <= next_word;
		end
	end

	assign round_evt = running && tick && step == `SDSC_STEP_LAST;
	assign err_evt = !error_flag && next_state == SDSC_FAULT;

	// a new event in the clearing cycle survives the write of one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_stat <= 2'h0;
		end else begin
			if (regs.wr && regs.addr == `SDSC_ADDR_INT_STAT) begin
				int_stat <= (int_stat & ~regs.wdata[1:0]) | {err_evt, round_evt};
			end else begin
				int_stat <= int_stat | {err_evt, round_evt};
			end
		end
	end

	assign irq = |(int_stat & int_mask);

	always_comb begin
		regs.rdata = `SDSC_RST_WORD;
		unique case (regs.addr)
			`SDSC_ADDR_CTRL: begin
				regs.rdata[7:0] = ctrl_mode;
				regs.rdata[`SDSC_CTRL_EXEC] = exec_en;
				regs.rdata[`SDSC_CTRL_AREA0_LSB +: 2] = area0;
				regs.rdata[`SDSC_CTRL_AREA1_LSB +: 2] = area1;
			end
			`SDSC_ADDR_SRC_LO: regs.rdata[15:0] = src_lo;
			`SDSC_ADDR_SRC_HI: regs.rdata[15:0] = src_hi;
			`SDSC_ADDR_GP_OUT: regs.rdata[15:0] = gp_out;
			`SDSC_ADDR_STATUS: regs.rdata[7:0] = {step, 1'b0, flag, error_flag, running};
			`SDSC_ADDR_INT_STAT: regs.rdata[1:0] = int_stat;
			`SDSC_ADDR_INT_MASK: regs.rdata[1:0] = int_mask;
			`SDSC_ADDR_OUT_WORD: regs.rdata[15:0] = seg_word;
			default: regs.rdata = `SDSC_RST_WORD;
		endcase
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_round_wrap: assert property (round_evt |=> step == 4'h0)
		else $error("round did not wrap after twelve steps");
	a_step_range: assert property (step <= `SDSC_STEP_LAST)
		else $error("step left the twelve-cycle round");
	a_step_advance: assert property (running && tick && !start && step != `SDSC_STEP_LAST
		|=> step == $past(step) + 4'h1)
		else $error("step did not advance on scan tick");
	a_idle_quiet: assert property (!running |=> seg_word == $past(gp_out))
		else $error("output changed while not executing");
	a_four_map: assert property (running && !eight
		|=> seg_word[7:4] == $past(strobes) && seg_word[15:9] == $past(gp_out[15:9]))
		else $error("four-digit strobe or spare bits wrong");
	a_eight_map: assert property (running && eight
		|=> seg_word[7:4] == $past(nib_hi) && seg_word[11:8] == $past(strobes))
		else $error("eight-digit data or strobe bits wrong");
	a_flag_bit: assert property (running && eight && step == `SDSC_STEP_LAST
		|=> seg_word[12] == 1'b1)
		else $error("round flag missing in last cycle");
	a_start_fresh: assert property (start |=> step == 4'h0 && running)
		else $error("sequence did not restart at step zero");
	a_error_set: assert property (exec_en && err_cond |=> error_flag && !display_busy_bit)
		else $error("bad operand did not raise error");
	a_busy_exec: assert property (exec_en && !err_cond |=> display_busy_bit)
		else $error("busy bit not on while executing");
	a_refresh: assert property (round_evt |=> snap_lo == $past(src_lo))
		else $error("source not reread at round end");
	a_latch_order: assert property (running && tick && !start && sdsc_phase(step) == 2'h0
		|=> latch_on && digit == $past(digit))
		else $error("strobe did not follow its data");
	a_mode_decode: assert property (running && ctrl_mode == 8'h03 && !latch_on
		|=> seg_word[7:4] == 4'hf)
		else $error("latch polarity decode wrong");

	c_round_eight: cover property (running && eight && round_evt);
	c_round_four: cover property (running && !eight && round_evt);
	c_area_fault: cover property (err_evt && ctrl_mode <= `SDSC_MODE_MAX);
	c_restart: cover property (restart);
endmodule

/* sim/sdsc_disp_model.sv */
// latched seven-segment display model on the scan driver's output word
`timescale 1ns/1ps
module sdsc_disp_model (
	input wire logic hclk,
	input wire logic [15:0] seg_word,
	input wire logic eight,
	input wire logic inv_data,
	input wire logic inv_latch,
	output logic [31:0] shown,
	output int period
);
	logic [3:0] strobe;
	logic [3:0] last_strobe = 4'h0;
	logic flag;
	logic last_flag = 1'b0;
	int since = 0;
	// lines are read in the display's own logic sense, set to match the control value
	assign strobe = (eight ? seg_word[11:8] : seg_word[7:4]) ^ {4{inv_latch}};
	assign flag = eight ? seg_word[12] : seg_word[8];
	// four data lines shared per half, one latch per digit pair; a digit keeps its data when its latch fires
	always @(posedge hclk) begin
		for (int d = 0; d < 4; d++) begin
			if (strobe[d] && !last_strobe[d]) begin
				shown[4*d +: 4] <= seg_word[3:0] ^ {4{inv_data}};
				shown[16+4*d +: 4] <= seg_word[7:4] ^ {4{inv_data}};
			end
		end
		last_strobe <= strobe;
		last_flag <= flag;
		since <= (flag && !last_flag) ? 1 : since + 1;
		// clocks between two round flags
		if (flag && !last_flag) begin
			period <= since;
		end
	end
endmodule

/* sim/tb_seven_segment_scan_driver.sv */
// self-checking bench for the segment display scan driver
`timescale 1ns/1ps
`include "sdsc_params.svh"
module tb_seven_segment_scan_driver;
	localparam int DIV = 4;
	localparam int RND = 12 * DIV;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [31:0] shown;
	logic hready;
	logic hresp;
	logic busy;
	logic err;
	logic irq;
	logic [15:0] seg;
	logic [15:0] gp = 16'ha5c3;
	logic [7:0] mode = 8'h00;
	logic [31:0] ev [3] = '{32'h0000_0108, 32'h0000_1104, 32'h0000_1100};
	int period;
	int bad_count = 0;
	int checked = 0;

	initial begin
		forever #25 hclk = ~hclk;
	end

	sdsc_top #(.SCAN_DIV(DIV)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .seg_word(seg),
		.display_busy_bit(busy), .error_flag(err), .irq(irq));

	sdsc_disp_model disp (.hclk(hclk), .seg_word(seg), .eight(mode[2]), .inv_data(mode[1]),
		.inv_latch(mode[0]), .shown(shown), .period(period));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// called just after a rising edge; returns at the edge that ends the data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic flags(input logic [31:0] exp);
		chk({29'h0000_0000, irq, err, busy}, exp);
	endtask

	// output bits outside the run-time part must still equal gp; upper digits are unused with four digits
	task automatic run_chk(input logic [31:0] v);
		logic [15:0] msk;
		msk = mode[2] ? 16'he000 : 16'hfe00;
		chk(mode[2] ? shown : {16'h0000, shown[15:0]}, mode[2] ? v : {16'h0000, v[15:0]});
		chk(32'(period), 32'(RND));
		chk({16'h0000, seg & msk}, {16'h0000, gp & msk});
		chk({31'h0000_0000, busy}, 32'h0000_0001);
	endtask

	task automatic close_out;
		$display("compares %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(`SDSC_ADDR_CTRL, 32'h0000_0000);
		rdchk(`SDSC_ADDR_OUT_WORD, 32'h0000_0000);
		xfer(1'b1, 8'h20, 32'hffff_ffff);
		rdchk(8'h20, 32'h0000_0000);
		xfer(1'b1, `SDSC_ADDR_GP_OUT, {16'h0000, gp});
		xfer(1'b1, `SDSC_ADDR_SRC_LO, 32'h0000_1234);
		xfer(1'b1, `SDSC_ADDR_SRC_HI, 32'h0000_5678);
		@(posedge hclk);
		chk({16'h0000, seg}, {16'h0000, gp});
		// every control value in range, each with the execution bit
		for (int m = 0; m < 8; m++) begin
			mode <= 8'(m);
			xfer(1'b1, `SDSC_ADDR_CTRL, 32'h0000_0100 | 32'(m));
			repeat (2 * RND + 14) @(posedge hclk);
			run_chk(32'h5678_1234);
		end
		xfer(1'b1, `SDSC_ADDR_SRC_LO, 32'h0000_9087);
		repeat (2 * RND + 14) @(posedge hclk);
		run_chk(32'h5678_9087);
		xfer(1'b1, `SDSC_ADDR_CTRL, 32'h0000_0307);
		rdchk(`SDSC_ADDR_STATUS, 32'h0000_0001);
		xfer(1'b1, `SDSC_ADDR_CTRL, 32'h0000_0000);
		// state flop, then output register, must both follow the cleared bit
		repeat (3) @(posedge hclk);
		chk({16'h0000, seg}, {16'h0000, gp});
		flags(32'h0000_0000);
		rdchk(`SDSC_ADDR_INT_STAT, 32'h0000_0001);
		xfer(1'b1, `SDSC_ADDR_INT_MASK, 32'h0000_0003);
		@(posedge hclk);
		flags(32'h0000_0004);
		xfer(1'b1, `SDSC_ADDR_INT_STAT, 32'h0000_0001);
		@(posedge hclk);
		flags(32'h0000_0000);
		// bad value, eight digits over split areas, four digits over split areas
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, `SDSC_ADDR_CTRL, ev[i]);
			repeat (3) @(posedge hclk);
			flags(i < 2 ? 32'h0000_0006 : 32'h0000_0001);
			rdchk(`SDSC_ADDR_INT_STAT, i < 2 ? 32'h0000_0002 : 32'h0000_0000);
			if (i < 2)
				chk({16'h0000, seg}, {16'h0000, gp});
			xfer(1'b1, `SDSC_ADDR_CTRL, 32'h0000_0000);
			xfer(1'b1, `SDSC_ADDR_INT_STAT, 32'h0000_0003);
		end
		xfer(1'b1, `SDSC_ADDR_CTRL, 32'h0000_0104);
		repeat (20) @(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({15'h0000, busy, seg}, 32'h0000_0000);
		hresetn <= 1'b1;
		close_out;
	end

	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		close_out;
	end
endmodule
